// ==== src/rcr_map.vh ====
`ifndef RCR_MAP_VH
`define RCR_MAP_VH

// Register offsets
`define RCR_ADDR_W        12
`define RCR_OFS_PIN2_CFG  12'h011
`define RCR_OFS_LOG_CTRL  12'h012
`define RCR_OFS_IRQ_SEL   12'h014
`define RCR_OFS_IRQ_ACK   12'h015
`define RCR_OFS_PWR_MARK  12'h016
`define RCR_OFS_UPD_LOCK  12'h017
`define RCR_OFS_TRIGGER   12'h018
`define RCR_OFS_THR_HIGH  12'h019
`define RCR_OFS_THR_LOW   12'h01a
`define RCR_OFS_PERIOD    12'h01b
`define RCR_OFS_IRQ_STAT  12'h04f
`define RCR_OFS_LOG_BASE  12'h052
`define RCR_LOG_IDX_MSB   2

// Reset values
`define RCR_RST_PIN2_CFG  8'h20
`define RCR_RST_PWR_MARK  1'h1
`define RCR_RST_THR_HIGH  8'hff
`define RCR_RST_THR_LOW   8'h00
`define RCR_RST_PERIOD    8'hff

// Field positions
`define RCR_PIN2_POL      5
`define RCR_PIN2_FN_MSB   4
`define RCR_PIN2_FN_LSB   1
`define RCR_LOG_EN        0
`define RCR_LOG_MODE      1
`define RCR_LOG_CLR       2
`define RCR_ACK_RANGE     0
`define RCR_ACK_ERROR     2
`define RCR_TRIG_GO       0
`define RCR_TRIG_CONT     1

// Encodings
`define RCR_FN_HIZ        4'h0
`define RCR_FN_IRQ        4'h8
`define RCR_MODE_OFF      3'h0
`define RCR_MODE_LOW      3'h1
`define RCR_MODE_HIGH     3'h2
`define RCR_MODE_WINDOW   3'h3
`define RCR_MODE_NEW      3'h4

// Timing
`define RCR_CLK_HZ        20000000
`define RCR_STEP_MS       10

`endif

// ==== src/rcr_ctrl.v ====
// How it works
// - Pin function 0000 floats, 1000 drives interrupt
// - Polarity bit 5 picks active-low or high
// - Log clear bit wipes buffer, then self-clears
// - Log keeps eight newest 8-bit results
// - Results logged only while enable bit set
// - 3-bit mode selects range interrupt source
// - Low, high, window comparisons raise range interrupt
// - Compare millimetre result against 8-bit thresholds
// - Ack bit0 clears range, bit2 error
// - Clear acts only on the write itself
// - Marker set on reset, host may zero
// - Trigger bit1 picks single-shot or continuous
// - Single-shot start launches exactly one measurement
// - Continuous start toggles repeated ranging on/off
// - Start bit returns to zero after action
// - Continuous gap is period times 10 ms, a zero period counting as one
`timescale 1ns/10ps
`include "rcr_map.vh"

module rcr_ctrl #(
    parameter STEP_CYCLES = (`RCR_CLK_HZ / 1000) * `RCR_STEP_MS,
    parameter LOG_DEPTH = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register access from the serial bus front end
    input wire reg_wr,
    input wire reg_rd,
    input wire [`RCR_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Measurement engine
    output wire meas_start,
    input wire meas_done,
    input wire [7:0] meas_result,
    input wire meas_error,
    output reg [7:0] act_thr_high,
    output reg [7:0] act_thr_low,
    output reg [7:0] act_period,
    // Second output pin
    output wire second_output_pin_o,
    output wire second_output_pin_oe
);

    localparam ST_IDLE = 2'd0;
    localparam ST_MEAS = 2'd1;
    localparam ST_GAP = 2'd2;
    localparam CW = 32;
    localparam [7:0] PIN2_RST = `RCR_RST_PIN2_CFG;

    function hit;
        input [`RCR_ADDR_W-1:0] a;
        input [`RCR_ADDR_W-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // ------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------
    reg pin_two_active_level_q;
    reg [3:0] pin_two_function_q;
    reg log_en_q;
    reg log_mode_q;
    reg log_clr_q;
    reg [2:0] irq_mode_q;
    reg power_up_marker_q;
    reg upd_lock_q;
    reg trig_go_q;
    reg trig_cont_q;
    reg [7:0] thr_high_q;
    reg [7:0] thr_low_q;
    reg [7:0] period_q;
    reg range_irq_q;
    reg error_irq_q;
    reg [1:0] state_q;
    reg run_q;
    reg [CW-1:0] gap_cnt_q;
    reg [7:0] log_q [0:LOG_DEPTH-1];

    wire wr_trig = reg_wr && hit(reg_addr, `RCR_OFS_TRIGGER);
    wire wr_ack = reg_wr && hit(reg_addr, `RCR_OFS_IRQ_ACK);
    wire idle = (state_q == ST_IDLE);
    // Single-shot waits for idle; continuous toggles at once
    wire act_go = trig_go_q && (trig_cont_q || idle);
    wire cont_begin = act_go && trig_cont_q && !run_q;
    wire cont_halt = act_go && trig_cont_q && run_q;
    wire gap_over = (state_q == ST_GAP) && (gap_cnt_q == {CW{1'b0}});
    assign meas_start = (act_go && !trig_cont_q)
        || (cont_begin && idle)
        || (gap_over && run_q && !cont_halt);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_two_active_level_q <= PIN2_RST[`RCR_PIN2_POL];
            pin_two_function_q <=
                PIN2_RST[`RCR_PIN2_FN_MSB:`RCR_PIN2_FN_LSB];
            log_en_q <= 1'b0;
            log_mode_q <= 1'b0;
            log_clr_q <= 1'b0;
            irq_mode_q <= `RCR_MODE_OFF;
            power_up_marker_q <= `RCR_RST_PWR_MARK;
            upd_lock_q <= 1'b0;
            trig_go_q <= 1'b0;
            trig_cont_q <= 1'b0;
            thr_high_q <= `RCR_RST_THR_HIGH;
            thr_low_q <= `RCR_RST_THR_LOW;
            period_q <= `RCR_RST_PERIOD;
        end else begin
            if (log_clr_q) begin
                log_clr_q <= 1'b0;
            end
            if (act_go) begin
                trig_go_q <= 1'b0;
            end
            if (reg_wr) begin
                if (hit(reg_addr, `RCR_OFS_PIN2_CFG)) begin
                    pin_two_active_level_q <= reg_wdata[`RCR_PIN2_POL];
                    pin_two_function_q <=
                        reg_wdata[`RCR_PIN2_FN_MSB:`RCR_PIN2_FN_LSB];
                end
                if (hit(reg_addr, `RCR_OFS_LOG_CTRL)) begin
                    log_en_q <= reg_wdata[`RCR_LOG_EN];
                    log_mode_q <= reg_wdata[`RCR_LOG_MODE];
                    log_clr_q <= reg_wdata[`RCR_LOG_CLR];
                end
                if (hit(reg_addr, `RCR_OFS_IRQ_SEL)) begin
                    irq_mode_q <= reg_wdata[2:0];
                end
                if (hit(reg_addr, `RCR_OFS_PWR_MARK)) begin
                    power_up_marker_q <= reg_wdata[0];
                end
                if (hit(reg_addr, `RCR_OFS_UPD_LOCK)) begin
                    upd_lock_q <= reg_wdata[0];
                end
                if (wr_trig) begin
                    trig_go_q <= reg_wdata[`RCR_TRIG_GO];
                    trig_cont_q <= reg_wdata[`RCR_TRIG_CONT];
                end
                if (hit(reg_addr, `RCR_OFS_THR_HIGH)) begin
                    thr_high_q <= reg_wdata;
                end
                if (hit(reg_addr, `RCR_OFS_THR_LOW)) begin
                    thr_low_q <= reg_wdata;
                end
                if (hit(reg_addr, `RCR_OFS_PERIOD)) begin
                    period_q <= reg_wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Settings copy and sequencer
    // ------------------------------------------------------------
    // Zero period still waits one step
    wire [7:0] steps = (act_period == 8'h00) ? 8'h01 : act_period;
    wire [CW-1:0] gap_load = steps * STEP_CYCLES - 1;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            act_thr_high <= `RCR_RST_THR_HIGH;
            act_thr_low <= `RCR_RST_THR_LOW;
            act_period <= `RCR_RST_PERIOD;
            state_q <= ST_IDLE;
            run_q <= 1'b0;
            gap_cnt_q <= {CW{1'b0}};
        end else begin
            // Half-written settings never reach the engine
            if (meas_start && !upd_lock_q) begin
                act_thr_high <= thr_high_q;
                act_thr_low <= thr_low_q;
                act_period <= period_q;
            end
            if (cont_begin) begin
                run_q <= 1'b1;
            end
            if (cont_halt) begin
                run_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (meas_start) begin
                        state_q <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (meas_done) begin
                        if (run_q && !cont_halt) begin
                            state_q <= ST_GAP;
                            gap_cnt_q <= gap_load;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_GAP: begin
                    if (!run_q || cont_halt) begin
                        state_q <= ST_IDLE;
                    end else if (gap_over) begin
                        state_q <= ST_MEAS;
                    end else begin
                        gap_cnt_q <= gap_cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire below = meas_result < act_thr_low;
    wire above = meas_result > act_thr_high;
    reg range_hit;

    always @* begin
        case (irq_mode_q)
            `RCR_MODE_LOW: range_hit = below;
            `RCR_MODE_HIGH: range_hit = above;
            `RCR_MODE_WINDOW: range_hit = below || above;
            `RCR_MODE_NEW: range_hit = 1'b1;
            default: range_hit = 1'b0;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            range_irq_q <= 1'b0;
            error_irq_q <= 1'b0;
        end else begin
            // A new event in the clearing cycle wins
            if (meas_done && range_hit) begin
                range_irq_q <= 1'b1;
            end else if (wr_ack && reg_wdata[`RCR_ACK_RANGE]) begin
                range_irq_q <= 1'b0;
            end
            if (meas_error) begin
                error_irq_q <= 1'b1;
            end else if (wr_ack && reg_wdata[`RCR_ACK_ERROR]) begin
                error_irq_q <= 1'b0;
            end
        end
    end

    wire irq_any = range_irq_q || error_irq_q;
    assign second_output_pin_oe =
        (pin_two_function_q == `RCR_FN_IRQ);
    assign second_output_pin_o =
        pin_two_active_level_q ? irq_any : !irq_any;

    // ------------------------------------------------------------
    // Result log
    // ------------------------------------------------------------
    // Mode 1 has no use, so nothing is logged then
    wire log_push = meas_done && log_en_q && !log_mode_q;

    genvar gi;
    generate
        for (gi = 0; gi < LOG_DEPTH; gi = gi + 1) begin : g_log
            wire [7:0] src;
            if (gi == 0) begin : g_first
                assign src = meas_result;
            end else begin : g_next
                assign src = log_q[gi-1];
            end
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    log_q[gi] <= 8'h00;
                end else if (log_clr_q) begin
                    log_q[gi] <= 8'h00;
                end else if (log_push) begin
                    log_q[gi] <= src;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [`RCR_ADDR_W-1:0] log_ofs = reg_addr - `RCR_OFS_LOG_BASE;
    wire log_hit = (reg_addr >= `RCR_OFS_LOG_BASE) &&
        (log_ofs < LOG_DEPTH);
    reg [7:0] rd_d;

    always @* begin
        rd_d = 8'h00;
        if (log_hit) begin
            rd_d = log_q[log_ofs[`RCR_LOG_IDX_MSB:0]];
        end else begin
            case (reg_addr)
                `RCR_OFS_PIN2_CFG: rd_d = {2'h0, pin_two_active_level_q,
                    pin_two_function_q, 1'b0};
                `RCR_OFS_LOG_CTRL: rd_d = {5'h00, log_clr_q, log_mode_q,
                    log_en_q};
                `RCR_OFS_IRQ_SEL: rd_d = {5'h00, irq_mode_q};
                `RCR_OFS_PWR_MARK: rd_d = {7'h00, power_up_marker_q};
                `RCR_OFS_UPD_LOCK: rd_d = {7'h00, upd_lock_q};
                `RCR_OFS_TRIGGER: rd_d = {6'h00, trig_cont_q, trig_go_q};
                `RCR_OFS_THR_HIGH: rd_d = thr_high_q;
                `RCR_OFS_THR_LOW: rd_d = thr_low_q;
                `RCR_OFS_PERIOD: rd_d = period_q;
                `RCR_OFS_IRQ_STAT: rd_d = {5'h00, error_irq_q, 1'b0,
                    range_irq_q};
                default: rd_d = 8'h00;
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end
    end

endmodule // rcr_ctrl

// ==== test/rcr_chk.sv ====
`timescale 1ns/10ps
module rcr_chk (
    // Clock, reset and register side
    input wire clk,
    input wire rst,
    input wire reg_wr,
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    // Engine side and pin
    input wire meas_start,
    input wire meas_done,
    input wire [7:0] meas_result,
    input wire meas_error,
    input wire [7:0] act_thr_high,
    input wire [7:0] act_thr_low,
    input wire [7:0] act_period,
    input wire second_output_pin_o,
    input wire second_output_pin_oe
);
    reg [7:0] cfg_q, thr_h_q, thr_l_q;
    reg [2:0] mode_q;
    reg hold_q;
    // Shadow copies of the settings, so expectations need no internal probe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q <= 8'h20;
            mode_q <= 3'h0;
            hold_q <= 1'b0;
            thr_h_q <= 8'hff;
            thr_l_q <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                12'h011: cfg_q <= reg_wdata;
                12'h014: mode_q <= reg_wdata[2:0];
                12'h017: hold_q <= reg_wdata[0];
                12'h019: thr_h_q <= reg_wdata;
                12'h01a: thr_l_q <= reg_wdata;
                default: ;
            endcase
        end
    end
    wire irq_seen = (second_output_pin_o == cfg_q[5]);
    wire ack_wr = reg_wr && (reg_addr == 12'h015);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_over;
        meas_done && !ack_wr && (mode_q == 3'h2 || mode_q == 3'h3)
            && meas_result > act_thr_high;
    endsequence
    sequence s_under;
        meas_done && !ack_wr && (mode_q == 3'h1 || mode_q == 3'h3)
            && meas_result < act_thr_low;
    endsequence
    property p_pin_drive;
        second_output_pin_oe == (cfg_q[4:1] == 4'h8);
    endproperty
    property p_start_pulse;
        meas_start |=> !meas_start;
    endproperty
    property p_hold_keep;
        meas_start && hold_q |=> $stable(act_thr_high) && $stable(act_thr_low)
            && $stable(act_period);
    endproperty
    property p_copy;
        meas_start && !hold_q && !reg_wr |=> act_thr_high == $past(thr_h_q)
            && act_thr_low == $past(thr_l_q);
    endproperty
    property p_irq_high;
        s_over |=> irq_seen;
    endproperty
    property p_irq_low;
        s_under |=> irq_seen;
    endproperty
    property p_irq_new;
        meas_done && !ack_wr && mode_q == 3'h4 |=> irq_seen;
    endproperty
    property p_irq_off;
        meas_done && mode_q == 3'h0 && !irq_seen && !meas_error && !reg_wr
            |=> !irq_seen;
    endproperty
    property p_irq_hold;
        irq_seen && !reg_wr |=> irq_seen;
    endproperty
    property p_ack;
        ack_wr && reg_wdata[0] && reg_wdata[2] && !meas_done && !meas_error
            |=> !irq_seen;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("pin enable disagrees with function field");
    a_start_pulse: assert property (p_start_pulse)
        else $error("measurement start longer than one cycle");
    a_hold_keep: assert property (p_hold_keep)
        else $error("settings copied while held");
    a_copy: assert property (p_copy)
        else $error("thresholds not copied at start");
    a_irq_high: assert property (p_irq_high)
        else $error("high threshold interrupt missing");
    a_irq_low: assert property (p_irq_low)
        else $error("low threshold interrupt missing");
    a_irq_new: assert property (p_irq_new)
        else $error("new sample interrupt missing");
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt raised while disabled");
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without clear");
    a_ack: assert property (p_ack)
        else $error("clear write left interrupt pending");
endmodule // rcr_chk
bind rcr_ctrl rcr_chk chk_u (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .meas_start(meas_start),
    .meas_done(meas_done), .meas_result(meas_result),
    .meas_error(meas_error), .act_thr_high(act_thr_high),
    .act_thr_low(act_thr_low), .act_period(act_period),
    .second_output_pin_o(second_output_pin_o),
    .second_output_pin_oe(second_output_pin_oe));

// ==== test/rcr_engine.sv ====
`timescale 1ns/10ps
module rcr_engine #(parameter int LAT = 3) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Measurement handshake
    input wire meas_start,
    input wire [7:0] base,
    output logic meas_done,
    output logic [7:0] meas_result
);
    int cnt;
    int n;
    // Result is base plus count of earlier finished measurements
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            n <= 0;
            meas_done <= 1'b0;
            meas_result <= 8'h00;
        end else begin
            meas_done <= 1'b0;
            // Not valid outside done: toggle so stale data never matches
            meas_result <= ~meas_result;
            if (meas_start) begin
                cnt <= LAT;
            end else if (cnt == 1) begin
                meas_done <= 1'b1;
                meas_result <= base + n[7:0];
                n <= n + 1;
                cnt <= 0;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // rcr_engine

// ==== test/rcr_ctrl_bench.sv ====
`timescale 1ns/10ps
module rcr_ctrl_bench;
    localparam int STEP = 4;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, meas_error = 0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00, rv;
    wire [7:0] reg_rdata, meas_result, act_thr_high, act_thr_low, act_period;
    wire meas_start, meas_done, pin_o, pin_oe;
    int fails = 0, check_count = 0, cyc = 0, starts = 0, dones = 0;
    int gap = 0, last_d = 0, s0 = 0;
    // Row: write flag, offset, write data, expected read
    logic [28:0] rows [14] = '{{1'b0, 12'h011, 8'h00, 8'h20},
        {1'b0, 12'h016, 8'h00, 8'h01}, {1'b0, 12'h019, 8'h00, 8'hff},
        {1'b0, 12'h01b, 8'h00, 8'hff}, {1'b1, 12'h011, 8'h10, 8'h10},
        {1'b1, 12'h012, 8'h03, 8'h03}, {1'b1, 12'h012, 8'h01, 8'h01},
        {1'b1, 12'h014, 8'h02, 8'h02},
        {1'b1, 12'h015, 8'h05, 8'h00}, {1'b1, 12'h016, 8'h00, 8'h00},
        {1'b1, 12'h019, 8'hc8, 8'hc8}, {1'b1, 12'h01a, 8'h32, 8'h32},
        {1'b1, 12'h01b, 8'h00, 8'h00}, {1'b1, 12'h0ff, 8'h55, 8'h00}};
    rcr_ctrl #(.STEP_CYCLES(STEP)) dut_u (.clk(clk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .meas_start(meas_start), .meas_done(meas_done),
        .meas_result(meas_result), .meas_error(meas_error),
        .act_thr_high(act_thr_high), .act_thr_low(act_thr_low),
        .act_period(act_period), .second_output_pin_o(pin_o),
        .second_output_pin_oe(pin_oe));
    rcr_engine eng_u (.clk(clk), .rst(rst), .meas_start(meas_start),
        .base(8'hd2), .meas_done(meas_done), .meas_result(meas_result));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (meas_start) begin
            starts++;
            gap = cyc - last_d;
        end
        if (meas_done) begin
            dones++;
            last_d = cyc;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic wait_done(input int k);
        int n;
        n = 0;
        while (dones < k && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (dones < k)
            fails++;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #(50 * 5000);
        fails++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i][28])
                wr(rows[i][27:16], rows[i][15:8]);
            rd(rows[i][27:16], rv);
            chk(rv, rows[i][7:0]);
        end
        chk({7'h0, pin_oe}, 8'h01);
        chk({7'h0, pin_o}, 8'h01);
        // Single shot above high threshold, pin active low
        wr(12'h018, 8'h01);
        wait_done(1);
        chk(starts[7:0], 8'h01);
        chk({7'h0, pin_o}, 8'h00);
        chk(act_thr_high, 8'hc8);
        rd(12'h04f, rv);
        chk(rv, 8'h01);
        rd(12'h018, rv);
        chk(rv, 8'h00);
        rd(12'h052, rv);
        chk(rv, 8'hd2);
        wr(12'h015, 8'h01);
        chk({7'h0, pin_o}, 8'h01);
        // Held settings are not copied; an old clear does not persist
        wr(12'h017, 8'h01);
        wr(12'h019, 8'h10);
        wr(12'h018, 8'h01);
        wait_done(2);
        chk(act_thr_high, 8'hc8);
        chk({7'h0, pin_o}, 8'h00);
        wr(12'h017, 8'h00);
        // Logging off: entry keeps the earlier result
        wr(12'h012, 8'h00);
        wr(12'h015, 8'h05);
        wr(12'h018, 8'h01);
        wait_done(3);
        rd(12'h052, rv);
        chk(rv, 8'hd3);
        // Error interrupt needs its own clear bit
        @(posedge clk);
        wr(12'h015, 8'h01);
        @(posedge clk);
        meas_error <= 1'b1;
        @(posedge clk);
        meas_error <= 1'b0;
        wr(12'h015, 8'h01);
        chk({7'h0, pin_o}, 8'h00);
        rd(12'h04f, rv);
        chk(rv, 8'h04);
        wr(12'h015, 8'h04);
        chk({7'h0, pin_o}, 8'h01);
        // Level-low source, then window source for the continuous run
        wr(12'h014, 8'h01);
        wr(12'h01a, 8'hff);
        wr(12'h018, 8'h01);
        wait_done(4);
        chk({7'h0, pin_o}, 8'h00);
        wr(12'h015, 8'h01);
        wr(12'h014, 8'h03);
        // Clear and re-enable the log, then run continuously
        wr(12'h012, 8'h05);
        rd(12'h012, rv);
        chk(rv, 8'h01);
        rd(12'h052, rv);
        chk(rv, 8'h00);
        wr(12'h018, 8'h03);
        wait_done(8);
        chk({7'h0, gap == STEP}, 8'h01);
        wr(12'h01b, 8'h02);
        wait_done(13);
        wr(12'h018, 8'h03);
        chk({7'h0, gap == 2 * STEP}, 8'h01);
        chk(act_period, 8'h02);
        repeat (20) @(posedge clk);
        s0 = starts;
        repeat (40) @(posedge clk);
        chk(starts[7:0], s0[7:0]);
        rd(12'h018, rv);
        chk(rv, 8'h02);
        for (int i = 0; i < 8; i++) begin
            rd(12'h052 + i, rv);
            chk(rv, 8'hd2 + dones[7:0] - 8'h01 - i[7:0]);
        end
        // Reset after the continuous run has stopped restores the marker and floats the pin
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(12'h016, rv);
        chk(rv, 8'h01);
        chk({7'h0, pin_oe}, 8'h00);
        test_done();
    end
endmodule // rcr_ctrl_bench
